// file: src/buck_fault_hiccup_control.sv
// fault counters, hiccup latch and soft-start sequencing of the buck regulator
// assumes asynchronous comparator levels and an AXI4-Lite master on the same clock
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns

module buck_fault_hiccup_control (
  input wire logic clock,
  input wire logic nrst,
  input wire buck_fault_pkg::cmp_t cmpIn,
  output buck_fault_pkg::drv_t drvOut,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // reset release pipe
  logic [1:0] rstPipe_ff;
  logic rstN; // synchronised reset, active low

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rstPipe_ff <= 2'h0;
    end else begin
      rstPipe_ff <= {rstPipe_ff[0], 1'b1};
    end
  end
  assign rstN = rstPipe_ff[1];

  // comparator synchronisers and edge history
  buck_fault_pkg::cmp_t sync1_ff; // first stage, read only by sync2_ff
  buck_fault_pkg::cmp_t sync2_ff; // usable level
  buck_fault_pkg::cmp_t sync3_ff; // previous level for edges

  // two stages before any logic reads the levels
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end else begin
      sync1_ff <= cmpIn;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // sequencer state
  buck_fault_pkg::phase_t phase_ff, nxt_phase;
  logic [6:0] ocCnt_ff, nxt_ocCnt; // overcurrent pulses
  logic [6:0] bootOpenCnt_ff, nxt_bootOpenCnt; // cycles with capacitor missing
  logic [6:0] bootShortCnt_ff, nxt_bootShortCnt; // cycles with capacitor shorted
  logic [1:0] negCnt_ff, nxt_negCnt; // cycles with switch node negative
  logic [15:0] hiccups_ff, nxt_hiccups; // hiccup entries seen
  buck_fault_pkg::drv_t drv_ff, nxt_drv;
  logic [31:0] ctrl_ff, nxt_ctrl; // software control register

  logic ocRise; // new overcurrent pulse
  logic cycRise; // new switching cycle
  logic armed; // fault counting allowed
  logic runOk; // regulator enabled and cool
  logic ocTrip, bootOpenTrip, bootShortTrip, diodeTrip, trip;

  // fault counting and phase sequencing
  always_comb begin
    ocRise = sync2_ff.ocPulse & ~sync3_ff.ocPulse;
    cycRise = sync2_ff.pwmCycle & ~sync3_ff.pwmCycle;
    armed = (phase_ff == buck_fault_pkg::PH_START) || (phase_ff == buck_fault_pkg::PH_RUN);
    runOk = sync2_ff.enable & ctrl_ff[0] & ~sync2_ff.thermalShutdown;
    nxt_phase = phase_ff;
    nxt_hiccups = hiccups_ff;

    // overcurrent counter only runs above threshold and while clamped
    if (!armed || !sync2_ff.ssAboveHiccup || !sync2_ff.compClamp) begin
      nxt_ocCnt = 7'h00;
    end else if (ocRise) begin
      nxt_ocCnt = ocCnt_ff + 7'h01;
    end else begin
      nxt_ocCnt = ocCnt_ff;
    end
    ocTrip = (nxt_ocCnt == buck_fault_pkg::OVERCURRENT_COUNT_LIMIT);

    // boot faults count switching cycles and drop when the fault goes away
    if (!armed || !sync2_ff.bootOpen) begin
      nxt_bootOpenCnt = 7'h00;
    end else if (cycRise) begin
      nxt_bootOpenCnt = bootOpenCnt_ff + 7'h01;
    end else begin
      nxt_bootOpenCnt = bootOpenCnt_ff;
    end
    bootOpenTrip = (nxt_bootOpenCnt == buck_fault_pkg::BOOT_OPEN_LIMIT);

    // a shorted boot capacitor is ignored while overvoltage is seen
    if (!armed || !sync2_ff.bootShort || sync2_ff.fbOverVolt) begin
      nxt_bootShortCnt = 7'h00;
    end else if (cycRise) begin
      nxt_bootShortCnt = bootShortCnt_ff + 7'h01;
    end else begin
      nxt_bootShortCnt = bootShortCnt_ff;
    end
    bootShortTrip = (nxt_bootShortCnt == buck_fault_pkg::BOOT_SHORT_LIMIT);

    // negative switch node must last the least time, counter saturates
    if (!armed || !sync2_ff.swBelowNeg) begin
      nxt_negCnt = 2'h0;
    end else if (negCnt_ff != buck_fault_pkg::DIODE_MIN_CYC) begin
      nxt_negCnt = negCnt_ff + 2'h1;
    end else begin
      nxt_negCnt = negCnt_ff;
    end
    diodeTrip = (nxt_negCnt == buck_fault_pkg::DIODE_MIN_CYC);

    // single shorted-diode fault trips with no counting
    trip = armed & (ocTrip | bootOpenTrip | bootShortTrip | diodeTrip
                    | sync2_ff.hsExtremeCurrent);

    case (phase_ff)
      buck_fault_pkg::PH_START: begin
        // charging, wait for the offset before switching
        if (trip) begin
          nxt_phase = buck_fault_pkg::PH_HICCUP;
        end else if (sync2_ff.ssAboveOffset) begin
          nxt_phase = buck_fault_pkg::PH_RUN;
        end
      end
      buck_fault_pkg::PH_RUN: begin
        // switching, any fault limit enters hiccup
        if (trip) begin
          nxt_phase = buck_fault_pkg::PH_HICCUP;
        end else if (!sync2_ff.ssAboveOffset) begin
          nxt_phase = buck_fault_pkg::PH_START;
        end
      end
      buck_fault_pkg::PH_HICCUP: begin
        // slow discharge until the reset level, then a fresh soft start
        if (sync2_ff.ssAtReset) begin
          nxt_phase = buck_fault_pkg::PH_START;
        end
      end
      buck_fault_pkg::PH_HOLD: begin
        // restart only once cool, enabled and discharged
        if (runOk && sync2_ff.ssAtReset) begin
          nxt_phase = buck_fault_pkg::PH_START;
        end
      end
      default: begin
        nxt_phase = buck_fault_pkg::PH_HOLD;
      end
    endcase

    // disable and over-temperature override every phase
    if (!runOk) begin
      nxt_phase = buck_fault_pkg::PH_HOLD;
    end

    if (nxt_phase == buck_fault_pkg::PH_HICCUP && phase_ff != buck_fault_pkg::PH_HICCUP) begin
      nxt_hiccups = hiccups_ff + 16'h0001;
    end
  end

  // controls follow the next phase so they change with it
  always_comb begin
    nxt_drv = '0;
    nxt_drv.hiccupLatch = (nxt_phase == buck_fault_pkg::PH_HICCUP);
    nxt_drv.hiccupDischargeSink = (nxt_phase == buck_fault_pkg::PH_HICCUP);
    nxt_drv.compPullDown = (nxt_phase == buck_fault_pkg::PH_HICCUP)
                           || (nxt_phase == buck_fault_pkg::PH_HOLD);
    nxt_drv.ssPullDown = (nxt_phase == buck_fault_pkg::PH_HOLD);
    nxt_drv.softstartChargeSource = (nxt_phase == buck_fault_pkg::PH_START)
                                    || (nxt_phase == buck_fault_pkg::PH_RUN);
    // high side stops while feedback is too high, resumes when it drops
    nxt_drv.highSideEn = (nxt_phase == buck_fault_pkg::PH_RUN)
                         && !sync2_ff.fbOverVolt;
    // low side may still pull an externally driven output down
    nxt_drv.lowSideEn = (nxt_phase == buck_fault_pkg::PH_RUN);
    // open-drain power-good, only ever driven low
    nxt_drv.powerGoodNOut = 1'b0;
    nxt_drv.powerGoodNOe = sync2_ff.fbOverVolt || sync2_ff.thermalShutdown;
  end

  // sequencer registers
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      phase_ff <= buck_fault_pkg::PH_HOLD;
      ocCnt_ff <= 7'h00;
      bootOpenCnt_ff <= 7'h00;
      bootShortCnt_ff <= 7'h00;
      negCnt_ff <= 2'h0;
      hiccups_ff <= 16'h0000;
      drv_ff <= '0;
    end else begin
      phase_ff <= nxt_phase;
      ocCnt_ff <= nxt_ocCnt;
      bootOpenCnt_ff <= nxt_bootOpenCnt;
      bootShortCnt_ff <= nxt_bootShortCnt;
      negCnt_ff <= nxt_negCnt;
      hiccups_ff <= nxt_hiccups;
      drv_ff <= nxt_drv;
    end
  end
  assign drvOut = drv_ff;

  // AXI4-Lite slave state
  logic awready_ff, nxt_awready; // address and data taken together
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic arready_ff, nxt_arready;
  logic rvalid_ff, nxt_rvalid;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic wrTake, rdTake;

  // one write and one read at a time, ready pulses for one cycle
  always_comb begin
    wrTake = awready_ff & s_axi_awvalid & s_axi_wvalid;
    rdTake = arready_ff & s_axi_arvalid;
    nxt_awready = s_axi_awvalid & s_axi_wvalid & ~awready_ff & ~bvalid_ff;
    nxt_arready = s_axi_arvalid & ~arready_ff & ~rvalid_ff;
    nxt_ctrl = ctrl_ff;
    nxt_bvalid = bvalid_ff & ~s_axi_bready;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff & ~s_axi_rready;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    if (wrTake) begin
      // only the control word is writable, lane 0 holds its bit
      nxt_bvalid = 1'b1;
      if (s_axi_awaddr == buck_fault_pkg::ADDR_CTRL) begin
        nxt_bresp = buck_fault_pkg::RESP_OKAY;
        if (s_axi_wstrb[0]) begin
          nxt_ctrl = {31'h0000_0000, s_axi_wdata[0]};
        end
      end else if (s_axi_awaddr == buck_fault_pkg::ADDR_STATUS
                   || s_axi_awaddr == buck_fault_pkg::ADDR_HICCUPS) begin
        nxt_bresp = buck_fault_pkg::RESP_OKAY; // read-only, write ignored
      end else begin
        nxt_bresp = buck_fault_pkg::RESP_SLVERR; // unmapped
      end
    end
    if (rdTake) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = buck_fault_pkg::RESP_OKAY;
      case (s_axi_araddr)
        buck_fault_pkg::ADDR_CTRL: begin
          nxt_rdata = ctrl_ff;
        end
        buck_fault_pkg::ADDR_STATUS: begin
          nxt_rdata = {17'h00000, ocCnt_ff, 3'h0, sync2_ff.fbOverVolt,
                       sync2_ff.thermalShutdown, drv_ff.hiccupLatch, phase_ff};
        end
        buck_fault_pkg::ADDR_HICCUPS: begin
          nxt_rdata = {16'h0000, hiccups_ff};
        end
        default: begin
          nxt_rdata = 32'h0000_0000;
          nxt_rresp = buck_fault_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // bus registers
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      awready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= 2'h0;
      rdata_ff <= 32'h0000_0000;
      ctrl_ff <= buck_fault_pkg::CTRL_RESET;
    end else begin
      awready_ff <= nxt_awready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      ctrl_ff <= nxt_ctrl;
    end
  end
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = awready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  // checks on the sequencer
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstN);

  oc_held_off_a: assert property (
    !sync2_ff.ssAboveHiccup |=> ocCnt_ff == 7'h00
  ) else $error("overcurrent counter ran below hiccup threshold");

  oc_counts_a: assert property (
    armed && sync2_ff.ssAboveHiccup && sync2_ff.compClamp && ocRise && ocCnt_ff < 7'h77
    |=> ocCnt_ff == $past(ocCnt_ff) + 7'h01
  ) else $error("overcurrent pulse not counted");

  clamp_clears_a: assert property (
    $fell(sync2_ff.compClamp) |=> ocCnt_ff == 7'h00
  ) else $error("clamp drop did not clear counter");

  oc_trip_a: assert property (
    phase_ff == buck_fault_pkg::PH_RUN && runOk && sync2_ff.ssAboveHiccup
    && sync2_ff.compClamp && ocRise && ocCnt_ff == 7'h77
    |=> phase_ff == buck_fault_pkg::PH_HICCUP && drvOut.compPullDown && drvOut.hiccupLatch
  ) else $error("count 120 did not set hiccup");

  sink_on_a: assert property (
    drvOut.hiccupLatch |-> drvOut.hiccupDischargeSink && !drvOut.softstartChargeSource
  ) else $error("hiccup without discharge sink");

  reset_level_a: assert property (
    phase_ff == buck_fault_pkg::PH_HICCUP && sync2_ff.ssAtReset && runOk
    |=> !drvOut.hiccupLatch && !drvOut.hiccupDischargeSink ##0 drvOut.softstartChargeSource
  ) else $error("reset level did not restart soft start");

  resume_a: assert property (
    phase_ff == buck_fault_pkg::PH_START && sync2_ff.ssAboveOffset && !trip && runOk
    |=> phase_ff == buck_fault_pkg::PH_RUN && !drvOut.compPullDown
  ) else $error("switching did not resume above offset");

  boot_open_a: assert property (
    armed && runOk && sync2_ff.bootOpen && cycRise && bootOpenCnt_ff == 7'h06
    |=> phase_ff == buck_fault_pkg::PH_HICCUP
  ) else $error("boot open fault missed seventh cycle");

  boot_ovp_a: assert property (
    sync2_ff.fbOverVolt |=> bootShortCnt_ff == 7'h00
  ) else $error("boot short counted during overvoltage");

  diode_short_a: assert property (
    armed && runOk && sync2_ff.hsExtremeCurrent |=> phase_ff == buck_fault_pkg::PH_HICCUP
  ) else $error("shorted diode did not enter hiccup");

  ovp_stop_a: assert property (
    sync2_ff.fbOverVolt |=> !drvOut.highSideEn && drvOut.powerGoodNOe
  ) else $error("overvoltage left high side running");

  thermal_hold_a: assert property (
    sync2_ff.thermalShutdown |=> phase_ff == buck_fault_pkg::PH_HOLD
    && drvOut.ssPullDown && drvOut.compPullDown && !drvOut.lowSideEn
  ) else $error("over-temperature did not pull nodes low");

endmodule

// file: src/buck_fault_pkg.sv
// constants, types and register map of the buck fault and hiccup sequencer
// assumes one 25 MHz oscillator clock and digitised comparator levels from the power stage
//
// Functional notes
// - overcurrent counter held off below hiccup threshold
// - count overcurrent pulses while above threshold, clamped
// - clamp flag low clears overcurrent counter
// - count 120 sets hiccup latch, compensation pull-down
// - hiccup latch enables small soft-start discharge sink
// - reset level clears latch, sink off, charge on
// - above offset release compensation, resume switching; code already releases compensation on entering PH_START
// - hiccup cycles repeat while short persists
// - boot capacitor missing: hiccup after 7 cycles
// - boot shorted: hiccup after 120, unless overvoltage
// - boot faults non-latched, same hiccup timing
// - switch node negative over 50 ns: hiccup
// - shorted catch diode: hiccup after one fault
// - overvoltage stops high side, power-good low
// - low side keeps working during overvoltage
// - overvoltage non-latched, recovers when feedback drops
// - over-temperature: stop, power-good low, pull nodes low
// - thermal shutdown non-latched, auto restart when cool

package buck_fault_pkg;

  // timing
  localparam int CLK_PERIOD_NS = 40; // oscillator period
  localparam int DIODE_MIN_NS = 50; // least time below the negative threshold
  localparam int DIODE_MIN_CYC_I = (DIODE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] DIODE_MIN_CYC = 2'(DIODE_MIN_CYC_I); // rounded up

  // fault counts
  localparam int CNT_W = 7; // width of the overcurrent and boot fault counters
  localparam logic [6:0] OVERCURRENT_COUNT_LIMIT = 7'h78; // 120 pulses
  localparam logic [6:0] BOOT_OPEN_LIMIT = 7'h07; // 7 switching cycles
  localparam logic [6:0] BOOT_SHORT_LIMIT = 7'h78; // 120 switching cycles

  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00; // bit 0 software enable
  localparam logic [7:0] ADDR_STATUS = 8'h04; // phase, latch and fault levels
  localparam logic [7:0] ADDR_HICCUPS = 8'h08; // number of hiccup entries
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001; // enabled after reset
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // sequencer phases
  typedef enum logic [1:0] {
    PH_START = 2'b00, // soft start charging, not yet switching
    PH_RUN = 2'b01, // switching
    PH_HICCUP = 2'b10, // hiccup latch set, slow discharge
    PH_HOLD = 2'b11 // disabled or overheated, nodes pulled low
  } phase_t;

  // digitised comparator levels from the analog stage
  typedef struct packed {
    logic ssAboveHiccup; // soft start above hiccup_enable_threshold
    logic ssAboveOffset; // soft start above the start offset
    logic ssAtReset; // soft start at or below softstart_reset_level
    logic compClamp; // comp_clamp_flag
    logic ocPulse; // overcurrent comparator pulse
    logic bootOpen; // boot capacitor missing
    logic bootShort; // boot capacitor shorted
    logic pwmCycle; // one pulse per switching cycle
    logic swBelowNeg; // switch_node below the diode-fault threshold
    logic hsExtremeCurrent; // shorted catch diode current
    logic fbOverVolt; // feedback_node above overvoltage_threshold
    logic thermalShutdown; // thermal_shutdown indication
    logic enable; // regulator enable
  } cmp_t;

  // controls to the analog stage
  typedef struct packed {
    logic hiccupLatch; // hiccup latch state
    logic compPullDown; // strong compensation pull-down
    logic hiccupDischargeSink; // hiccup_discharge_sink
    logic softstartChargeSource; // softstart_charge_source
    logic ssPullDown; // fast soft-start pull-down
    logic highSideEn; // high-side pulses allowed
    logic lowSideEn; // low-side switch allowed
    logic powerGoodNOut; // power_good_n output level
    logic powerGoodNOe; // power_good_n driven low when high
  } drv_t;

endpackage

// file: verif/analog_stage_model.sv
// soft-start node model of the analog stage beside the hiccup sequencer
// assumes the bench sets the fault levels and the design drives the node controls
`timescale 1ns/1ns

module analog_stage_model #(
  parameter int HICCUP_MV = 2300, // hiccup_enable_threshold
  parameter int OFFSET_MV = 400, // soft-start offset
  parameter int RESET_MV = 200 // softstart_reset_level
) (
  input wire logic clock,
  input wire buck_fault_pkg::cmp_t faults,
  input wire buck_fault_pkg::drv_t drv,
  output buck_fault_pkg::cmp_t cmpOut
);
  int ssMv = 0; // soft-start node level in millivolts

  // node ramps with whichever source or sink is on, the fast pull-down wins
  always @(posedge clock) begin
    if (drv.ssPullDown) begin
      ssMv <= (ssMv > 200) ? ssMv - 200 : 0; // fast discharge
    end else if (drv.hiccupDischargeSink && ssMv > 0) begin
      ssMv <= ssMv - 20; // slow hiccup timer
    end else if ((drv.softstartChargeSource || drv.lowSideEn) && ssMv < 3000) begin
      ssMv <= ssMv + 20; // soft start, then up toward the rail
    end
  end

  // node thresholds replace the bench's soft-start bits
  always_comb begin
    cmpOut = faults;
    cmpOut.ssAboveHiccup = (ssMv > HICCUP_MV);
    cmpOut.ssAboveOffset = (ssMv > OFFSET_MV);
    cmpOut.ssAtReset = (ssMv <= RESET_MV);
  end
endmodule

// file: verif/buck_fault_hiccup_control_tb_top.sv
// self-checking bench of the buck fault and hiccup sequencer
// assumes the analog stage model closes the soft-start loop around the design
`timescale 1ns/1ns

module buck_fault_hiccup_control_tb_top;
  localparam int LATCH = 8; // drvOut bit of the hiccup latch
  localparam int CHARGE = 5; // drvOut bit of the charge source
  localparam int PDN = 4; // drvOut bit of the soft-start pull-down
  localparam int LOWS = 2; // drvOut bit of the low-side enable
  logic clock = 1'b0; // oscillator
  logic nrst = 1'b0; // active-low reset
  buck_fault_pkg::cmp_t faults = 13'h0001; // enabled, no faults
  buck_fault_pkg::cmp_t cmpIn; // levels seen by the design
  buck_fault_pkg::drv_t drv; // controls from the design
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF; // write lanes
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [31:0] rd; // last read word
  logic [1:0] rsp; // last response code
  logic [16:0] rnd = 17'h11FD6; // lfsr state
  int miscompares = 0;
  int total_checks = 0;
  int hic = 0; // model count of hiccup entries
  int n; // random pulse count

  // free-running clock
  always #20 clock = ~clock;

  buck_fault_hiccup_control uut (.clock(clock), .nrst(nrst), .cmpIn(cmpIn), .drvOut(drv),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  analog_stage_model stage (.clock(clock), .faults(faults), .drv(drv), .cmpOut(cmpIn));

  // next random value
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    lfsr = {s[15:0], s[16] ^ s[13]};
  endfunction

  // expected controls per phase, 3 is the overheated hold
  function automatic buck_fault_pkg::drv_t ev(input logic [1:0] ph, input logic ov);
    ev = '0;
    case (ph)
      2'h0: ev.softstartChargeSource = 1'b1;
      2'h1: begin
        // charge source keeps the soft-start node rising while switching
        ev.softstartChargeSource = 1'b1;
        ev.highSideEn = !ov;
        ev.lowSideEn = 1'b1;
        ev.powerGoodNOe = ov;
      end
      2'h2: begin
        ev.hiccupLatch = 1'b1;
        ev.compPullDown = 1'b1;
        ev.hiccupDischargeSink = 1'b1;
      end
      default: begin
        ev.ssPullDown = 1'b1;
        ev.compPullDown = 1'b1;
        ev.powerGoodNOe = 1'b1;
      end
    endcase
  endfunction

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // one write: address and data together, then the response
  task wrReg(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge clock); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(posedge clock); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  // one read
  task rdReg(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clock); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  // bounded wait for one control bit to go high
  task waitBit(input int b);
    int i;
    for (i = 0; i < 3000 && drv[b] !== 1'b1; i++) @(posedge clock);
    if (i == 3000) chk(32'h0, 32'h1);
  endtask

  // n pulses on the overcurrent or the switching-cycle line
  task pulse(input int k, input bit pwm);
    repeat (k) begin
      if (pwm) faults.pwmCycle <= 1'b1;
      else faults.ocPulse <= 1'b1;
      @(posedge clock);
      faults.pwmCycle <= 1'b0;
      faults.ocPulse <= 1'b0;
      @(posedge clock);
    end
  endtask

  task countIs(input int c);
    repeat (4) @(posedge clock);
    rdReg(buck_fault_pkg::ADDR_STATUS);
    chk(32'(rd[14:8]), 32'(c));
  endtask

  // soft start then switching
  task toRun;
    waitBit(CHARGE);
    chk(32'(drv), 32'(ev(2'h0, 1'b0)));
    waitBit(LOWS);
    chk(32'(drv), 32'(ev(2'h1, 1'b0)));
  endtask

  // no hiccup after k-1 counted pulses, hiccup after the k-th, then restart
  task hiccupAfter(input int k, input bit pwm);
    while (!pwm && !cmpIn.ssAboveHiccup) @(posedge clock);
    repeat (4) @(posedge clock);
    pulse(k - 1, pwm);
    repeat (4) @(posedge clock);
    chk(32'(drv), 32'(ev(2'h1, 1'b0)));
    pulse(1, pwm);
    waitBit(LATCH);
    chk(32'(drv), 32'(ev(2'h2, 1'b0)));
    hic++;
    toRun();
  endtask

  // watchdog
  initial begin
    repeat (30000) @(posedge clock);
    miscompares++;
    stop_test();
  end

  initial begin
    repeat (4) @(posedge clock);
    chk(32'(drv), 32'h0);
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    rdReg(buck_fault_pkg::ADDR_CTRL);
    chk(rd, buck_fault_pkg::CTRL_RESET);
    wstrb <= 4'h0;
    wrReg(buck_fault_pkg::ADDR_CTRL, 32'h0); // lane 0 masked, write dropped
    wstrb <= 4'hF;
    rdReg(buck_fault_pkg::ADDR_CTRL);
    chk(rd, buck_fault_pkg::CTRL_RESET);
    rdReg(8'h0C); // unmapped
    chk({rd[31:2], rsp}, {30'h0, buck_fault_pkg::RESP_SLVERR});
    rnd = lfsr(rnd);
    wrReg(buck_fault_pkg::ADDR_STATUS, {15'h0, rnd}); // read-only
    chk(32'(rsp), 32'(buck_fault_pkg::RESP_OKAY));
    faults.compClamp <= 1'b1;
    toRun();
    pulse(20, 1'b0); // soft start still below the hiccup threshold
    countIs(0);
    while (!cmpIn.ssAboveHiccup) @(posedge clock);
    repeat (4) @(posedge clock);
    n = 10 + int'(rnd % 17'd100);
    pulse(n, 1'b0);
    countIs(n);
    faults.compClamp <= 1'b0;
    countIs(0);
    faults.compClamp <= 1'b1;
    hiccupAfter(120, 1'b0);
    hiccupAfter(120, 1'b0);
    faults.compClamp <= 1'b0;
    faults.bootOpen <= 1'b1;
    hiccupAfter(7, 1'b1);
    faults.bootOpen <= 1'b0;
    faults.bootShort <= 1'b1;
    faults.fbOverVolt <= 1'b1;
    repeat (4) @(posedge clock);
    chk(32'(drv), 32'(ev(2'h1, 1'b1)));
    pulse(130, 1'b1);
    chk(32'(drv), 32'(ev(2'h1, 1'b1)));
    faults.fbOverVolt <= 1'b0;
    repeat (4) @(posedge clock);
    chk(32'(drv), 32'(ev(2'h1, 1'b0)));
    hiccupAfter(120, 1'b1);
    faults.bootShort <= 1'b0;
    faults.swBelowNeg <= 1'b1;
    @(posedge clock);
    faults.swBelowNeg <= 1'b0;
    repeat (5) @(posedge clock);
    chk(32'(drv), 32'(ev(2'h1, 1'b0)));
    faults.swBelowNeg <= 1'b1;
    repeat (2) @(posedge clock);
    faults.swBelowNeg <= 1'b0;
    waitBit(LATCH);
    hic++;
    toRun();
    faults.hsExtremeCurrent <= 1'b1;
    @(posedge clock);
    faults.hsExtremeCurrent <= 1'b0;
    waitBit(LATCH);
    hic++;
    toRun();
    faults.thermalShutdown <= 1'b1;
    repeat (3) @(posedge clock);
    chk(32'(drv.highSideEn), 32'h1);
    @(posedge clock);
    chk(32'(drv), 32'(ev(2'h3, 1'b0)));
    repeat (20) @(posedge clock);
    faults.thermalShutdown <= 1'b0;
    toRun();
    wrReg(buck_fault_pkg::ADDR_CTRL, 32'h0);
    waitBit(PDN);
    rdReg(buck_fault_pkg::ADDR_STATUS);
    chk(32'(rd[1:0]), 32'h3);
    wrReg(buck_fault_pkg::ADDR_CTRL, 32'h1);
    toRun();
    rdReg(buck_fault_pkg::ADDR_HICCUPS);
    chk(rd, 32'(hic));
    stop_test();
  end
endmodule
